// ===== rpf_pkg.sv
// shared constants and types for the reset pin glitch filter
// assumes a byte-wide register port on the 50 MHz bus clock
package rpf_pkg;

    // ==========================================================
    // register offsets (byte addresses)
    localparam logic [2:0] RPF_OFS_CTRL   = 3'h4;
    localparam logic [2:0] RPF_OFS_WIDTH  = 3'h5;
    localparam logic [2:0] RPF_OFS_STATUS = 3'h6;

    // ==========================================================
    // field positions
    localparam int RPF_CTRL_RUN_LSB   = 0;
    localparam int RPF_CTRL_STOP_BIT  = 2;
    localparam int RPF_WIDTH_LSB      = 0;
    localparam int RPF_STAT_LVL_BIT   = 0;
    localparam int RPF_STAT_MODE_LSB  = 1;

    // ==========================================================
    // reset values (power-on only)
    localparam logic [1:0] RPF_RUN_SEL_RST  = 2'h0;
    localparam logic       RPF_STOP_SEL_RST = 1'b0;
    localparam logic [4:0] RPF_WIDTH_RST    = 5'h00;

    // ==========================================================
    // run/wait select encodings
    localparam logic [1:0] RPF_RUN_OFF = 2'h0;
    localparam logic [1:0] RPF_RUN_BUS = 2'h1;
    localparam logic [1:0] RPF_RUN_SLOW = 2'h2;

    // ==========================================================
    // timing counts
    localparam int RPF_SLOW_COUNT_DEF = 3;

    typedef enum logic [1:0] {
        RPF_MODE_OFF,
        RPF_MODE_BUS,
        RPF_MODE_SLOW
    } rpf_mode_t;

    typedef struct packed {
        logic       wr_en;
        logic       rd_en;
        logic [2:0] addr;
        logic [7:0] wdata;
    } rpf_bus_req_t;

    typedef struct packed {
        logic       stop_sel;
        logic [1:0] run_sel;
        logic [4:0] width;
        logic [5:0] bus_cnt;
        logic [5:0] slow_cnt;
        logic       slow_prev;
        logic       pin_lvl;
        logic [7:0] rdata;
    } rpf_state_t;

endpackage : rpf_pkg

// ===== rpf_filter.sv
// reset pin glitch filter with control, width and status registers
// assumes pin, mode and low-power clock inputs are synchronous to core_clk;
// nrst is chip power-on reset, warm_rst marks any other reset type
//
// Notes on behaviour
// [RQ1] mode selects reset only at power-on
// [RQ2] bus filter cleared when off or stopped
// [RQ3] low-power filter cleared when disabled
// [RQ4] stop select bit: off or low-power filter
// [RQ5] software rewrites stop select after leakage exit
// [RQ6] run select: off, bus, low-power, reserved
// [RQ7] bus filter count is width plus one
// [RQ8] width field reset only at power-on
// [RQ9] unused register bits read zero
// [RQ10] level accepted after N stable samples
// [RQ11] low-power filter uses fixed sample count
//
// The plain strobed port was decided locally.
`timescale 1ns/10ps

module rpf_filter #(
    parameter int SLOW_COUNT = rpf_pkg::RPF_SLOW_COUNT_DEF
) (
    input  wire logic                 core_clk,      // bus clock, 50 MHz
    input  wire logic                 nrst,          // power-on reset, low
    input  wire logic                 warm_rst,      // other reset types
    input  wire rpf_pkg::rpf_bus_req_t bus_req,      // register request
    output logic [7:0]                rd_data,       // read data, next cycle
    input  wire logic                 stop_mode,     // any stop or leakage mode
    input  wire logic                 low_power_oscillator_clock, // low-power clock level
    input  wire logic                 rst_pin_b,     // raw reset pin, low
    output logic                      filt_pin_b     // filtered reset pin
);
    import rpf_pkg::*;

    rpf_state_t s_q;
    rpf_state_t s_d;
    rpf_mode_t  mode;
    logic       slow_edge;

    // ==========================================================
    // helpers
    function automatic rpf_mode_t sel_mode(
        input logic       stp,
        input logic       ssel,
        input logic [1:0] rsel
    );
        rpf_mode_t m;
        m = RPF_MODE_OFF;
        if (stp) begin
            if (ssel) begin
                m = RPF_MODE_SLOW;                      // RQ4
            end
        end else begin
            case (rsel)
                RPF_RUN_BUS: m = RPF_MODE_BUS;           // RQ6
                RPF_RUN_SLOW: m = RPF_MODE_SLOW;         // RQ6
                default:     m = RPF_MODE_OFF;           // RQ6
            endcase
        end
        return m;
    endfunction : sel_mode

    function automatic logic [7:0] status_byte(
        input logic      lvl,
        input rpf_mode_t m
    );
        logic [7:0] b;
        b = 8'h00;
        b[RPF_STAT_LVL_BIT] = lvl;
        b[RPF_STAT_MODE_LSB +: 2] = m;
        return b;
    endfunction : status_byte

    // ==========================================================
    // next state
    always_comb begin
        s_d      = s_q;
        mode     = sel_mode(stop_mode, s_q.stop_sel, s_q.run_sel);
        slow_edge     = low_power_oscillator_clock && !s_q.slow_prev;
        s_d.slow_prev = low_power_oscillator_clock;
        s_d.rdata    = 8'h00;

        // register reads see the value before any later write
        if (bus_req.rd_en) begin
            case (bus_req.addr)
                RPF_OFS_CTRL: begin
                    s_d.rdata[RPF_CTRL_RUN_LSB +: 2] = s_q.run_sel;  // RQ9
                    s_d.rdata[RPF_CTRL_STOP_BIT]     = s_q.stop_sel;
                end
                RPF_OFS_WIDTH: begin
                    s_d.rdata[RPF_WIDTH_LSB +: 5] = s_q.width;       // RQ9
                end
                RPF_OFS_STATUS: begin
                    s_d.rdata = status_byte(s_q.pin_lvl, mode);
                end
                default: s_d.rdata = 8'h00;
            endcase
        end

        // reserved bits are simply not stored
        if (bus_req.wr_en) begin
            case (bus_req.addr)
                RPF_OFS_CTRL: begin
                    s_d.run_sel  = bus_req.wdata[RPF_CTRL_RUN_LSB +: 2];
                    s_d.stop_sel = bus_req.wdata[RPF_CTRL_STOP_BIT];
                end
                RPF_OFS_WIDTH: begin
                    s_d.width = bus_req.wdata[RPF_WIDTH_LSB +: 5];
                end
                default: s_d.width = s_q.width;
            endcase
        end

        // bus clock filter: counts core_clk samples
        if (mode != RPF_MODE_BUS) begin
            s_d.bus_cnt = 6'h00;                                     // RQ2
        end else if (rst_pin_b == s_q.pin_lvl) begin
            s_d.bus_cnt = 6'h00;                                     // RQ10
        end else if (s_q.bus_cnt >= {1'b0, s_q.width}) begin
            s_d.pin_lvl = rst_pin_b;                                 // RQ7
            s_d.bus_cnt = 6'h00;
        end else begin
            s_d.bus_cnt = s_q.bus_cnt + 6'h01;                       // RQ10
        end

        // low-power filter: counts rising edges of the slow clock
        if (mode != RPF_MODE_SLOW) begin
            s_d.slow_cnt = 6'h00;                                    // RQ3
        end else if (rst_pin_b == s_q.pin_lvl) begin
            s_d.slow_cnt = 6'h00;                                    // RQ10
        end else if (slow_edge) begin
            if (s_q.slow_cnt >= 6'(SLOW_COUNT - 1)) begin
                s_d.pin_lvl  = rst_pin_b;                            // RQ11
                s_d.slow_cnt = 6'h00;
            end else begin
                s_d.slow_cnt = s_q.slow_cnt + 6'h01;                 // RQ11
            end
        end

        if (mode == RPF_MODE_OFF) begin
            s_d.pin_lvl = rst_pin_b;                                 // RQ4
        end

        // other resets clear the filter counts but keep the settings and the filtered level;
        // software must redo the stop select after leakage exit
        if (warm_rst) begin
            s_d.bus_cnt = 6'h00;                                     // RQ1
            s_d.slow_cnt = 6'h00;                                    // RQ8
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_q          <= '0;
            s_q.run_sel  <= RPF_RUN_SEL_RST;                         // RQ1
            s_q.stop_sel <= RPF_STOP_SEL_RST;                        // RQ1
            s_q.width    <= RPF_WIDTH_RST;                           // RQ8
            s_q.pin_lvl  <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign rd_data    = s_q.rdata;
    assign filt_pin_b = s_q.pin_lvl;

    // ==========================================================
    // assertions
    default clocking cb @(posedge core_clk);
    endclocking

    default disable iff (!nrst);

    wire logic wr_ctrl  = bus_req.wr_en && bus_req.addr == RPF_OFS_CTRL;
    wire logic wr_width = bus_req.wr_en && bus_req.addr == RPF_OFS_WIDTH;
    wire logic rd_ctrl  = bus_req.rd_en && bus_req.addr == RPF_OFS_CTRL;
    wire logic rd_width = bus_req.rd_en && bus_req.addr == RPF_OFS_WIDTH;

    a_ctrl_keep_warm : assert property ( // RQ1
        warm_rst && !wr_ctrl |=> $stable({s_q.stop_sel, s_q.run_sel}))
        else $error("control select changed under warm reset");

    a_width_keep_warm : assert property ( // RQ8
        warm_rst && !wr_width |=> $stable(s_q.width))
        else $error("width changed under warm reset");

    a_bus_clear_stop : assert property ( // RQ2
        stop_mode |=> s_q.bus_cnt == 6'h00)
        else $error("bus filter count kept in stop mode");

    a_slow_clear_off : assert property ( // RQ3
        mode != RPF_MODE_SLOW |=> s_q.slow_cnt == 6'h00)
        else $error("low-power filter count kept while disabled");

    a_stop_pass_thru : assert property ( // RQ4
        stop_mode && !s_q.stop_sel |=> filt_pin_b == $past(rst_pin_b))
        else $error("pin filtered although stop filtering is off");

    a_stop_no_bus : assert property ( // RQ4
        stop_mode && s_q.stop_sel |-> mode == RPF_MODE_SLOW)
        else $error("stop select did not choose low-power filter");

    a_run_select : assert property ( // RQ6
        !stop_mode && s_q.run_sel == RPF_RUN_BUS |-> mode == RPF_MODE_BUS)
        else $error("run select 01 did not choose bus filter");

    a_run_reserved : assert property ( // RQ6
        !stop_mode && s_q.run_sel == 2'h3 |=> filt_pin_b == $past(rst_pin_b))
        else $error("reserved run select did not pass pin through");

    a_bus_one_clock : assert property ( // RQ7
        mode == RPF_MODE_BUS && s_q.width == 5'h00 && !warm_rst
        && rst_pin_b != filt_pin_b |=> filt_pin_b == $past(rst_pin_b))
        else $error("width zero did not filter for one clock");

    a_bus_width_hit : assert property ( // RQ7
        mode == RPF_MODE_BUS && !warm_rst && rst_pin_b != filt_pin_b
        && s_q.bus_cnt == {1'b0, s_q.width} |=> filt_pin_b == $past(rst_pin_b))
        else $error("bus filter did not flip at width plus one");

    a_bus_too_soon : assert property ( // RQ10
        mode == RPF_MODE_BUS && s_q.bus_cnt < {1'b0, s_q.width}
        |=> $stable(filt_pin_b))
        else $error("bus filter flipped before count reached");

    a_flip_to_pin : assert property ( // RQ10
        $changed(filt_pin_b) |-> filt_pin_b == $past(rst_pin_b))
        else $error("filtered pin moved to a level the pin did not have");

    a_slow_needs_edge : assert property ( // RQ11
        mode == RPF_MODE_SLOW && !slow_edge |=> $stable(filt_pin_b))
        else $error("low-power filter flipped without a slow clock edge");

    a_resv_ctrl : assert property ( // RQ9
        rd_ctrl |=> rd_data[7:3] == 5'h00)
        else $error("control reserved bits read non-zero");

    a_resv_width : assert property ( // RQ9
        rd_width |=> rd_data[7:5] == 3'h0)
        else $error("width reserved bits read non-zero");

    a_width_store : assert property ( // RQ7
        wr_width ##1 rd_width |=> rd_data[4:0] == $past(bus_req.wdata[4:0], 2))
        else $error("width field did not read back");

    // counters are scratch state: a warm reset must not leave a half count
    a_warm_clear_cnt : assert property ( // RQ10
        warm_rst |=> s_q.bus_cnt == 6'h00 && s_q.slow_cnt == 6'h00)
        else $error("filter counts kept through warm reset");

    a_run_slow_sel : assert property ( // RQ6
        !stop_mode && s_q.run_sel == RPF_RUN_SLOW |-> mode == RPF_MODE_SLOW)
        else $error("run select 10 did not choose low-power filter");

    a_run_off_sel : assert property ( // RQ6
        !stop_mode && s_q.run_sel == RPF_RUN_OFF |=> filt_pin_b == $past(rst_pin_b))
        else $error("run select 00 did not pass pin through");

    a_width_keep_stop : assert property ( // RQ8
        stop_mode && !wr_width |=> $stable(s_q.width))
        else $error("width changed in stop mode");

    a_ctrl_keep_stop : assert property ( // RQ1
        stop_mode && !wr_ctrl |=> $stable({s_q.stop_sel, s_q.run_sel}))
        else $error("control selects changed in stop mode");

    a_ctrl_store : assert property ( // RQ9
        wr_ctrl ##1 rd_ctrl |=> rd_data[2:0] == $past(bus_req.wdata[2:0], 2))
        else $error("control selects did not read back");

    a_rd_idle_zero : assert property ( // RQ9
        !bus_req.rd_en |=> rd_data == 8'h00)
        else $error("read data not zero outside a read");

    a_slow_count_hit : assert property ( // RQ11
        mode == RPF_MODE_SLOW && slow_edge && !warm_rst && rst_pin_b != filt_pin_b
        && s_q.slow_cnt == 6'(SLOW_COUNT - 1) |=> filt_pin_b == $past(rst_pin_b))
        else $error("low-power filter did not flip at its sample count");

    // status is what software uses to see which filter is really live
    a_stat_mode : assert property ( // RQ6
        bus_req.rd_en && bus_req.addr == RPF_OFS_STATUS
        |=> rd_data[2:1] == $past(mode))
        else $error("status did not report the active filter");

    c_bus_flip : cover property (
        mode == RPF_MODE_BUS && s_q.width == 5'h1f ##1 $changed(filt_pin_b));

    c_slow_flip : cover property (
        mode == RPF_MODE_SLOW ##1 $changed(filt_pin_b));

    c_slow_run : cover property (
        mode == RPF_MODE_SLOW && !stop_mode ##1 $changed(filt_pin_b));

    c_glitch_drop : cover property (
        mode == RPF_MODE_BUS && s_q.bus_cnt == 6'h03 ##1 s_q.bus_cnt == 6'h00
        && $stable(filt_pin_b));

    c_warm_keep : cover property (
        warm_rst && s_q.width != 5'h00);

endmodule : rpf_filter

// ===== rpf_pin_model.sv
// model of the external reset pin driver and the always-on low-power clock
// assumes the filter samples both levels on core_clk rising edges
`timescale 1ns/10ps

module rpf_pin_model #(
    parameter int SLOW_HALF = 2               // core cycles per low-power half period
) (
    input  wire logic core_clk,               // bus clock
    output logic      rst_pin_b,              // pin level, low = reset
    output logic      low_power_oscillator_clock // low-power clock level
);
    int div_q = 0;

    initial begin
        rst_pin_b                  = 1'b1;
        low_power_oscillator_clock = 1'b0;
    end

    // ==========================================================
    // always-on clock: runs free, it never stands still
    always @(posedge core_clk) begin
        div_q <= (div_q == SLOW_HALF - 1) ? 0 : div_q + 1;
        if (div_q == SLOW_HALF - 1) begin
            low_power_oscillator_clock <= ~low_power_oscillator_clock;
        end
    end

    // ==========================================================
    // pin held low for exactly n sampling edges
    task automatic pulse(input int n);
        @(posedge core_clk) rst_pin_b <= 1'b0;
        repeat (n) @(posedge core_clk);
        rst_pin_b <= 1'b1;
    endtask : pulse
endmodule : rpf_pin_model

// ===== tb.sv
// self-checking bench for the reset pin glitch filter
// assumes rpf_pkg and rpf_filter are compiled first
`timescale 1ns/10ps

module tb;
    import rpf_pkg::*;
    localparam int SLOW_N = 2;
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] width;
        logic       stop;
        logic [7:0] len;
        logic       low;
    } rpf_row_t;

    logic         core_clk, nrst, warm_rst, stop_mode, rst_pin_b, filt_pin_b;
    logic         low_power_oscillator_clock;
    rpf_bus_req_t bus_req;
    logic [7:0]   rd_data, v;
    logic         seen;
    int           errors = 0;
    int           total_checks = 0;
    // config, pulse length in edges, and whether the filtered pin drops
    rpf_row_t rows [13] = '{
        '{8'hf8, 8'he0, 1'b0, 8'h01, 1'b1}, '{8'h01, 8'h00, 1'b0, 8'h01, 1'b1},
        '{8'h01, 8'h02, 1'b0, 8'h02, 1'b0}, '{8'h01, 8'h02, 1'b0, 8'h03, 1'b1},
        '{8'h01, 8'h1f, 1'b0, 8'h1f, 1'b0}, '{8'h01, 8'hff, 1'b0, 8'h20, 1'b1},
        '{8'h03, 8'h00, 1'b0, 8'h01, 1'b1}, '{8'h02, 8'h00, 1'b0, 8'h01, 1'b0},
        '{8'h02, 8'h00, 1'b0, 8'h14, 1'b1}, '{8'h00, 8'h00, 1'b1, 8'h01, 1'b1},
        '{8'h04, 8'h00, 1'b1, 8'h01, 1'b0}, '{8'hfd, 8'h00, 1'b1, 8'h14, 1'b1},
        '{8'h05, 8'h00, 1'b1, 8'h01, 1'b0}};

    rpf_filter #(.SLOW_COUNT(SLOW_N)) uut (
        .core_clk   (core_clk),
        .nrst       (nrst),
        .warm_rst   (warm_rst),
        .bus_req    (bus_req),
        .rd_data    (rd_data),
        .stop_mode  (stop_mode),
        .low_power_oscillator_clock (low_power_oscillator_clock),
        .rst_pin_b  (rst_pin_b),
        .filt_pin_b (filt_pin_b)
    );

    rpf_pin_model pm (
        .core_clk  (core_clk),
        .rst_pin_b (rst_pin_b),
        .low_power_oscillator_clock (low_power_oscillator_clock)
    );

    // ==========================================================
    // bus cycles and compares
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk) bus_req <= '{1'b1, 1'b0, a, d};
        @(posedge core_clk) bus_req <= '0;
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge core_clk) bus_req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge core_clk) bus_req <= '0;
        #1 d = rd_data;
    endtask : rd

    // write then read back with no idle cycle between the strobes
    task automatic wr_rd(input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge core_clk) bus_req <= '{1'b1, 1'b0, a, d};
        @(posedge core_clk) bus_req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge core_clk) bus_req <= '0;
        #1 q = rd_data;
    endtask : wr_rd

    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] s);
        total_checks = total_checks + 1;
        if (s !== e) begin
            errors = errors + 1;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : chk8

    task automatic chk1(input string nm, input logic e, input logic s);
        total_checks = total_checks + 1;
        if (s !== e) begin
            errors = errors + 1;
            $display("ERROR %s expected %b seen %b", nm, e, s);
        end
    endtask : chk1

    // window long enough for a 32-count filter to drop and recover
    task automatic glitch(input int n, output logic low);
        logic hit;
        hit = 1'b0;
        fork
            pm.pulse(n);
            repeat (n + 45) @(negedge core_clk) if (filt_pin_b === 1'b0) hit = 1'b1;
        join
        low = hit;
    endtask : glitch

    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up

    // ==========================================================
    // clock, watchdog and main sequence
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    initial begin
        #200_000;
        errors = errors + 1;
        wrap_up();
    end

    initial begin
        nrst = 1'b0;
        warm_rst = 1'b0;
        stop_mode = 1'b0;
        bus_req = '0;
        repeat (16) @(posedge core_clk);
        nrst <= 1'b1;
        foreach (rows[i]) begin
            wr_rd(RPF_OFS_CTRL, rows[i].ctrl, v);
            chk8("control", rows[i].ctrl & 8'h07, v);
            wr_rd(RPF_OFS_WIDTH, rows[i].width, v);
            chk8("width", rows[i].width & 8'h1f, v);
            @(posedge core_clk) stop_mode <= rows[i].stop;
            glitch(rows[i].len, seen);
            chk1("pin dropped", rows[i].low, seen);
        end
        @(posedge core_clk) stop_mode <= 1'b0;
        wr(RPF_OFS_CTRL, 8'h05);
        wr(RPF_OFS_WIDTH, 8'h1a);
        @(posedge core_clk) warm_rst <= 1'b1;
        @(posedge core_clk) warm_rst <= 1'b0;
        rd(RPF_OFS_CTRL, v);
        chk8("control kept", 8'h05, v);
        rd(RPF_OFS_WIDTH, v);
        chk8("width kept", 8'h1a, v);
        wr(3'h7, 8'hff);
        rd(3'h7, v);
        chk8("unmapped", 8'h00, v);
        rd(RPF_OFS_CTRL, v);
        chk8("control intact", 8'h05, v);
        rd(RPF_OFS_STATUS, v);
        chk8("status", 8'h03, v);
        @(posedge core_clk) nrst <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1 chk1("pin in reset", 1'b1, filt_pin_b);
        @(posedge core_clk) nrst <= 1'b1;
        rd(RPF_OFS_CTRL, v);
        chk8("control reset", 8'h00, v);
        rd(RPF_OFS_WIDTH, v);
        chk8("width reset", 8'h00, v);
        wrap_up();
    end
endmodule : tb
